// File: include/byte_unit_pkg.sv
// Constants, operation codes and decode helpers of the byte logic, shift and bit unit.
//
// What this block does
// - AND destination with register or immediate.
// - OR destination with register or immediate.
// - XOR destination with register or immediate.
// - NOT replaces register with one's complement.
// - Arithmetic shifts left and right, written back.
// - Logical shifts left and right, written back.
// - Plain rotates leave carry out of the loop but copy the moved bit into it.
// - Carry rotates form a nine-bit path.
// - Bit number from immediate or register.
// - Bit set forces chosen bit one.
// - Bit clear forces chosen bit zero.
// - Bit invert toggles chosen bit only.
// - Bit probe loads zero with inverted bit.
// - Carry combines with bit by AND/OR/XOR.
// - Inverted variants combine carry with complement.
// - Inverted carry ops take immediate bit only.
// - Bit-to-carry copies bit into carry.
// - Inverted load puts complement into carry.
// - Carry-to-bit writes carry into bit.
// - Inverted store writes complemented carry.
// - Bit-modifying memory ops read, modify, write.
// - Write-only target reads back as all ones.
`default_nettype none
package byte_unit_pkg;

	localparam int BYTE_W = 8;
	localparam int BIT_W = 3;
	localparam int ADDR_W = 16;
	localparam logic [BYTE_W-1:0] ALL_ONES = 8'hFF;
	localparam logic [BYTE_W-1:0] BYTE_RESET = 8'h00;
	localparam logic [ADDR_W-1:0] ADDR_RESET = 16'h0000;
	localparam logic [BIT_W-1:0] BIT_RESET = 3'h0;

	// ---------------------------------------------------------------
	// Operations
	// ---------------------------------------------------------------
	typedef enum logic [4:0] {
		OP_AND = 5'b00000,
		OP_OR = 5'b00001,
		OP_XOR = 5'b00010,
		OP_NOT = 5'b00011,
		OP_ARITH_LEFT_SHIFT = 5'b00100,
		OP_ARITH_RIGHT_SHIFT = 5'b00101,
		OP_LOGIC_LEFT_SHIFT = 5'b00110,
		OP_LOGIC_RIGHT_SHIFT = 5'b00111,
		OP_ROTATE_LEFT = 5'b01000,
		OP_ROTATE_RIGHT = 5'b01001,
		OP_ROTATE_LEFT_VIA_CARRY = 5'b01010,
		OP_ROTATE_RIGHT_VIA_CARRY = 5'b01011,
		OP_BIT_ONE_WRITE = 5'b01100,
		OP_BIT_ZERO_WRITE = 5'b01101,
		OP_BIT_INVERT = 5'b01110,
		OP_BIT_PROBE = 5'b01111,
		OP_CARRY_AND_BIT = 5'b10000,
		OP_CARRY_AND_INVERTED_BIT = 5'b10001,
		OP_CARRY_OR_BIT = 5'b10010,
		OP_CARRY_OR_INVERTED_BIT = 5'b10011,
		OP_CARRY_XOR_BIT = 5'b10100,
		OP_CARRY_XOR_INVERTED_BIT = 5'b10101,
		OP_BIT_TO_CARRY = 5'b10110,
		OP_INVERTED_BIT_TO_CARRY = 5'b10111,
		OP_CARRY_TO_BIT = 5'b11000,
		OP_INVERTED_CARRY_TO_BIT = 5'b11001
	} op_type;

	// ---------------------------------------------------------------
	// Sequencer states
	// ---------------------------------------------------------------
	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_READ = 2'b01,
		ST_EXEC = 2'b10
	} state_type;

	// ---------------------------------------------------------------
	// Decode helpers
	// ---------------------------------------------------------------
	function automatic logic isBitOp(input op_type op);
		isBitOp = (op >= OP_BIT_ONE_WRITE);
	endfunction

	function automatic logic immBitOnly(input op_type op);
		immBitOnly = (op == OP_CARRY_AND_INVERTED_BIT) || (op == OP_CARRY_OR_INVERTED_BIT) ||
			(op == OP_CARRY_XOR_INVERTED_BIT) || (op == OP_INVERTED_BIT_TO_CARRY) ||
			(op == OP_INVERTED_CARRY_TO_BIT);
	endfunction

	function automatic logic isRmwOp(input op_type op);
		isRmwOp = (op == OP_BIT_ONE_WRITE) || (op == OP_BIT_ZERO_WRITE) || (op == OP_BIT_INVERT) ||
			(op == OP_CARRY_TO_BIT) || (op == OP_INVERTED_CARRY_TO_BIT);
	endfunction

	function automatic logic [BYTE_W-1:0] putBit(input logic [BYTE_W-1:0] data, input logic [BIT_W-1:0] idx,
		input logic val);
		logic [BYTE_W-1:0] tmp;
		tmp = data;
		tmp[idx] = val;
		putBit = tmp;
	endfunction

endpackage
`default_nettype wire

// File: logic/byte_op_core.sv
// Combinational result and flag generator for one byte operation.
`timescale 1ns/1ps
`default_nettype none
module byte_op_core
	import byte_unit_pkg::*;
(
	// Operation and operands
	input wire op_type op,
	input wire logic [BYTE_W-1:0] operand,
	input wire logic [BYTE_W-1:0] other,
	input wire logic [BIT_W-1:0] bitNum,
	input wire logic carryIn,
	// Results
	output logic [BYTE_W-1:0] result,
	output logic resultWrite,
	output logic carryOut,
	output logic carryWrite,
	output logic zeroOut,
	output logic zeroWrite,
	output logic negOut,
	output logic negWrite
);

	logic picked;

	assign picked = operand[bitNum];

	always_comb begin
		result = operand;
		resultWrite = 1'b1;
		carryOut = carryIn;
		carryWrite = 1'b0;
		zeroWrite = 1'b0;
		negWrite = 1'b0;
		case (op)
			OP_AND: result = operand & other;
			OP_OR: result = operand | other;
			OP_XOR: result = operand ^ other;
			OP_NOT: result = ~operand;
			OP_ARITH_LEFT_SHIFT, OP_LOGIC_LEFT_SHIFT: begin
				result = {operand[6:0], 1'b0};
				carryOut = operand[7];
			end
			OP_ARITH_RIGHT_SHIFT: begin
				result = {operand[7], operand[7:1]};
				carryOut = operand[0];
			end
			OP_LOGIC_RIGHT_SHIFT: begin
				result = {1'b0, operand[7:1]};
				carryOut = operand[0];
			end
			OP_ROTATE_LEFT: begin
				result = {operand[6:0], operand[7]};
				carryOut = operand[7];
			end
			OP_ROTATE_RIGHT: begin
				result = {operand[0], operand[7:1]};
				carryOut = operand[0];
			end
			OP_ROTATE_LEFT_VIA_CARRY: begin
				result = {operand[6:0], carryIn};
				carryOut = operand[7];
			end
			OP_ROTATE_RIGHT_VIA_CARRY: begin
				result = {carryIn, operand[7:1]};
				carryOut = operand[0];
			end
			OP_BIT_ONE_WRITE: result = putBit(operand, bitNum, 1'b1);
			OP_BIT_ZERO_WRITE: result = putBit(operand, bitNum, 1'b0);
			OP_BIT_INVERT: result = putBit(operand, bitNum, ~picked);
			OP_CARRY_TO_BIT: result = putBit(operand, bitNum, carryIn);
			OP_INVERTED_CARRY_TO_BIT: result = putBit(operand, bitNum, ~carryIn);
			OP_BIT_PROBE: resultWrite = 1'b0;
			OP_CARRY_AND_BIT: carryOut = carryIn & picked;
			OP_CARRY_OR_BIT: carryOut = carryIn | picked;
			OP_CARRY_XOR_BIT: carryOut = carryIn ^ picked;
			OP_CARRY_AND_INVERTED_BIT: carryOut = carryIn & ~picked;
			OP_CARRY_OR_INVERTED_BIT: carryOut = carryIn | ~picked;
			OP_CARRY_XOR_INVERTED_BIT: carryOut = carryIn ^ ~picked;
			OP_BIT_TO_CARRY: carryOut = picked;
			OP_INVERTED_BIT_TO_CARRY: carryOut = ~picked;
			default: resultWrite = 1'b0;
		endcase
		if (!isBitOp(op)) begin
			// Logic and shift results report sign and zero; shifts report the bit pushed out.
			negWrite = 1'b1;
			zeroWrite = 1'b1;
			carryWrite = (op >= OP_ARITH_LEFT_SHIFT);
		end else begin
			resultWrite = resultWrite && isRmwOp(op);
			carryWrite = !isRmwOp(op) && (op != OP_BIT_PROBE);
			zeroWrite = (op == OP_BIT_PROBE);
		end
		negOut = result[7];
		zeroOut = isBitOp(op) ? ~picked : (result == BYTE_RESET);
	end

endmodule
`default_nettype wire

// File: logic/byte_logic_shift_bit_unit.sv
// Sequencer of the byte logic, shift and bit unit with its memory read-modify-write port.
`timescale 1ns/1ps
`default_nettype none
module byte_logic_shift_bit_unit
	import byte_unit_pkg::*;
(
	// Clock and reset
	input wire logic clock,
	input wire logic rst,
	// Request
	input wire logic startValid,
	input wire op_type opCode,
	input wire logic [BYTE_W-1:0] destData,
	input wire logic [BYTE_W-1:0] srcData,
	input wire logic [BYTE_W-1:0] immData,
	input wire logic useImm,
	input wire logic [BIT_W-1:0] bitImm,
	input wire logic bitFromReg,
	input wire logic memTarget,
	input wire logic [ADDR_W-1:0] memAddrIn,
	input wire logic carryIn,
	// Memory port
	output logic memRead_ff,
	output logic memWrite_ff,
	output logic [ADDR_W-1:0] memAddr_ff,
	output logic [BYTE_W-1:0] memWrData_ff,
	input wire logic [BYTE_W-1:0] memRdData,
	input wire logic memRdValid,
	input wire logic memWriteOnly,
	// Results
	output logic busy_ff,
	output logic done_ff,
	output logic [BYTE_W-1:0] result_ff,
	output logic resultWrite_ff,
	output logic carry_ff,
	output logic carryWrite_ff,
	output logic zero_ff,
	output logic zeroWrite_ff,
	output logic negative_ff,
	output logic negWrite_ff
);

	// ---------------------------------------------------------------
	// Latched operation
	// ---------------------------------------------------------------
	state_type state_ff;
	state_type nxt_state;
	op_type op_ff;
	logic [BYTE_W-1:0] operand_ff;
	logic [BYTE_W-1:0] other_ff;
	logic [BIT_W-1:0] bit_ff;
	logic carryIn_ff;
	logic mem_ff;
	logic [BIT_W-1:0] nxt_bit;
	logic nxt_mem;

	logic [BYTE_W-1:0] coreResult;
	logic coreResultWrite;
	logic coreCarry;
	logic coreCarryWrite;
	logic coreZero;
	logic coreZeroWrite;
	logic coreNeg;
	logic coreNegWrite;

	logic startTaken;
	logic execNow;

	assign startTaken = (state_ff == ST_IDLE) && startValid;
	assign execNow = (state_ff == ST_EXEC);
	// The inverted carry group ignores the register bit source.
	assign nxt_bit = (bitFromReg && !immBitOnly(opCode)) ? srcData[BIT_W-1:0] : bitImm;
	// Only bit operations may name a memory byte.
	assign nxt_mem = memTarget && isBitOp(opCode);

	// ---------------------------------------------------------------
	// Sequencer
	// ---------------------------------------------------------------
	always_comb begin
		nxt_state = state_ff;
		case (state_ff)
			ST_IDLE: begin
				if (startValid) begin
					nxt_state = nxt_mem ? ST_READ : ST_EXEC;
				end
			end
			ST_READ: begin
				if (memRdValid) begin
					nxt_state = ST_EXEC;
				end
			end
			ST_EXEC: nxt_state = ST_IDLE;
			default: nxt_state = ST_IDLE;
		endcase
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			state_ff <= ST_IDLE;
		end else begin
			state_ff <= nxt_state;
		end
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			op_ff <= OP_AND;
			other_ff <= BYTE_RESET;
			bit_ff <= BIT_RESET;
			carryIn_ff <= 1'b0;
			mem_ff <= 1'b0;
		end else if (startTaken) begin
			op_ff <= opCode;
			other_ff <= useImm ? immData : srcData;
			bit_ff <= nxt_bit;
			carryIn_ff <= carryIn;
			mem_ff <= nxt_mem;
		end
	end

	// The operand comes from the register, or from the memory byte once read.
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			operand_ff <= BYTE_RESET;
		end else if (startTaken) begin
			operand_ff <= destData;
		end else if ((state_ff == ST_READ) && memRdValid) begin
			operand_ff <= memWriteOnly ? ALL_ONES : memRdData;
		end
	end

	// ---------------------------------------------------------------
	// Datapath
	// ---------------------------------------------------------------
	byte_op_core byte_op_core_inst (
		.op(op_ff),
		.operand(operand_ff),
		.other(other_ff),
		.bitNum(bit_ff),
		.carryIn(carryIn_ff),
		.result(coreResult),
		.resultWrite(coreResultWrite),
		.carryOut(coreCarry),
		.carryWrite(coreCarryWrite),
		.zeroOut(coreZero),
		.zeroWrite(coreZeroWrite),
		.negOut(coreNeg),
		.negWrite(coreNegWrite)
	);

	// ---------------------------------------------------------------
	// Memory port
	// ---------------------------------------------------------------
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			memRead_ff <= 1'b0;
			memWrite_ff <= 1'b0;
			memAddr_ff <= ADDR_RESET;
			memWrData_ff <= BYTE_RESET;
		end else begin
			memRead_ff <= startTaken && nxt_mem;
			memWrite_ff <= execNow && mem_ff && coreResultWrite;
			if (startTaken) begin
				memAddr_ff <= memAddrIn;
			end
			if (execNow) begin
				memWrData_ff <= coreResult;
			end
		end
	end

	// ---------------------------------------------------------------
	// Results and flags
	// ---------------------------------------------------------------
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			busy_ff <= 1'b0;
			done_ff <= 1'b0;
		end else begin
			busy_ff <= (nxt_state != ST_IDLE);
			done_ff <= execNow;
		end
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			result_ff <= BYTE_RESET;
			resultWrite_ff <= 1'b0;
			carry_ff <= 1'b0;
			carryWrite_ff <= 1'b0;
			zero_ff <= 1'b0;
			zeroWrite_ff <= 1'b0;
			negative_ff <= 1'b0;
			negWrite_ff <= 1'b0;
		end else begin
			resultWrite_ff <= execNow && !mem_ff && coreResultWrite;
			carryWrite_ff <= execNow && coreCarryWrite;
			zeroWrite_ff <= execNow && coreZeroWrite;
			negWrite_ff <= execNow && coreNegWrite;
			if (execNow) begin
				result_ff <= coreResult;
				carry_ff <= coreCarry;
				zero_ff <= coreZero;
				negative_ff <= coreNeg;
			end
		end
	end

	// ---------------------------------------------------------------
	// Assertions
	// ---------------------------------------------------------------
	default clocking cb @(posedge clock);
	endclocking
	default disable iff (rst);

	property p_and;
		execNow && (op_ff == OP_AND) |=> resultWrite_ff && (result_ff == ($past(operand_ff) & $past(other_ff)));
	endproperty
	a_and: assert property (p_and) else $error("AND result wrong.");

	property p_or;
		execNow && (op_ff == OP_OR) |=> resultWrite_ff && (result_ff == ($past(operand_ff) | $past(other_ff)));
	endproperty
	a_or: assert property (p_or) else $error("OR result wrong.");

	property p_xor;
		startTaken && (opCode == OP_XOR) && useImm |-> ##2 result_ff == ($past(destData, 2) ^ $past(immData, 2));
	endproperty
	a_xor: assert property (p_xor) else $error("XOR with immediate wrong.");

	property p_not;
		startTaken && (opCode == OP_NOT) |-> ##2 done_ff && (result_ff == ~$past(destData, 2));
	endproperty
	a_not: assert property (p_not) else $error("NOT result wrong.");

	property p_rotate_via_carry;
		execNow && (op_ff == OP_ROTATE_LEFT_VIA_CARRY)
			|=> ({carry_ff, result_ff} == {$past(operand_ff), $past(carryIn_ff)}) && carryWrite_ff;
	endproperty
	a_rotate_via_carry: assert property (p_rotate_via_carry) else $error("Carry rotate wrong.");

	property p_rotate_plain;
		execNow && (op_ff == OP_ROTATE_RIGHT) |=> result_ff == {$past(operand_ff[0]), $past(operand_ff[7:1])};
	endproperty
	a_rotate_plain: assert property (p_rotate_plain) else $error("Plain rotate wrong.");

	property p_imm_only_bit;
		startTaken && immBitOnly(opCode) |=> bit_ff == $past(bitImm);
	endproperty
	a_imm_only_bit: assert property (p_imm_only_bit) else $error("Inverted op used register bit.");

	property p_reg_bit;
		startTaken && bitFromReg && !immBitOnly(opCode) |=> bit_ff == $past(srcData[BIT_W-1:0]);
	endproperty
	a_reg_bit: assert property (p_reg_bit) else $error("Register bit number ignored.");

	property p_probe;
		execNow && (op_ff == OP_BIT_PROBE)
			|=> zeroWrite_ff && !resultWrite_ff && !memWrite_ff && (zero_ff == !$past(operand_ff[bit_ff]));
	endproperty
	a_probe: assert property (p_probe) else $error("Bit probe wrong.");

	property p_bit_to_carry;
		execNow && (op_ff == OP_INVERTED_BIT_TO_CARRY) |=> carryWrite_ff && (carry_ff == !$past(operand_ff[bit_ff]));
	endproperty
	a_bit_to_carry: assert property (p_bit_to_carry) else $error("Inverted bit load wrong.");

	property p_write_only;
		(state_ff == ST_READ) && memRdValid && memWriteOnly |=> operand_ff == ALL_ONES;
	endproperty
	a_write_only: assert property (p_write_only) else $error("Write-only read not all ones.");

	property p_rmw_set;
		(state_ff == ST_READ) && memRdValid && (op_ff == OP_BIT_ONE_WRITE)
			|-> ##2 memWrite_ff && (memWrData_ff == putBit($past(operand_ff), bit_ff, 1'b1));
	endproperty
	a_rmw_set: assert property (p_rmw_set) else $error("Memory bit set not written back.");

	property p_shift_flags;
		execNow && (op_ff == OP_LOGIC_RIGHT_SHIFT)
			|=> carryWrite_ff && (carry_ff == $past(operand_ff[0])) && (negative_ff == 1'b0);
	endproperty
	a_shift_flags: assert property (p_shift_flags) else $error("Shift flags wrong.");

	property p_carry_and_bit;
		execNow && (op_ff == OP_CARRY_AND_BIT)
			|=> carryWrite_ff && !resultWrite_ff && (carry_ff == ($past(carryIn_ff) & $past(operand_ff[bit_ff])));
	endproperty
	a_carry_and_bit: assert property (p_carry_and_bit) else $error("Carry AND bit wrong.");

	property p_bit_to_carry_plain;
		execNow && (op_ff == OP_BIT_TO_CARRY) |=> carryWrite_ff && (carry_ff == $past(operand_ff[bit_ff]));
	endproperty
	a_bit_to_carry_plain: assert property (p_bit_to_carry_plain) else $error("Bit load wrong.");

	property p_inv_carry_store;
		execNow && (op_ff == OP_INVERTED_CARRY_TO_BIT) && !mem_ff
			|=> resultWrite_ff && (result_ff == putBit($past(operand_ff), bit_ff, !$past(carryIn_ff)));
	endproperty
	a_inv_carry_store: assert property (p_inv_carry_store) else $error("Inverted store wrong.");

	c_reg_logic: cover property (startTaken && !nxt_mem ##2 done_ff && resultWrite_ff);
	c_mem_rmw: cover property (memRead_ff ##[1:8] memWrite_ff);
	c_write_only: cover property ((state_ff == ST_READ) && memRdValid && memWriteOnly);
	c_carry_op: cover property (done_ff && carryWrite_ff && !resultWrite_ff);
	c_probe: cover property (done_ff && zeroWrite_ff && !negWrite_ff);

endmodule
`default_nettype wire

// File: dv/tb_top.sv
// Self-checking testbench of the byte logic, shift and bit unit.
`timescale 1ns/1ps
`default_nettype none
module tb_top
	import byte_unit_pkg::*;
;
	// ---------------------------------------------------------------
	// Signals
	// ---------------------------------------------------------------
	typedef struct packed {
		logic [7:0] res;
		logic rW, c, cW, z, zW, n, nW, mR, mW;
		logic [7:0] mD;
		logic [15:0] addr;
	} exp_type;
	logic clock, rst, startValid, useImm, bitFromReg, memTarget, carryIn, memRdValid, memWriteOnly;
	op_type opCode;
	logic [7:0] destData, srcData, immData, memRdData, mByte;
	logic [2:0] bitImm;
	logic [15:0] memAddrIn;
	logic woV, rdSeen;
	logic memRead_ff, memWrite_ff, busy_ff, done_ff, resultWrite_ff, carry_ff, carryWrite_ff;
	logic zero_ff, zeroWrite_ff, negative_ff, negWrite_ff;
	logic [15:0] memAddr_ff;
	logic [7:0] memWrData_ff, result_ff;
	exp_type q[$];
	int mismatches = 0;
	int nTests = 0;
	int seedVal;

	byte_logic_shift_bit_unit byte_logic_shift_bit_unit_inst (.clock(clock), .rst(rst), .startValid(startValid),
		.opCode(opCode), .destData(destData), .srcData(srcData), .immData(immData), .useImm(useImm),
		.bitImm(bitImm), .bitFromReg(bitFromReg), .memTarget(memTarget), .memAddrIn(memAddrIn),
		.carryIn(carryIn), .memRead_ff(memRead_ff), .memWrite_ff(memWrite_ff), .memAddr_ff(memAddr_ff),
		.memWrData_ff(memWrData_ff), .memRdData(memRdData), .memRdValid(memRdValid),
		.memWriteOnly(memWriteOnly), .busy_ff(busy_ff), .done_ff(done_ff), .result_ff(result_ff),
		.resultWrite_ff(resultWrite_ff), .carry_ff(carry_ff), .carryWrite_ff(carryWrite_ff),
		.zero_ff(zero_ff), .zeroWrite_ff(zeroWrite_ff), .negative_ff(negative_ff), .negWrite_ff(negWrite_ff));

	initial begin
		clock = 1'h0;
		forever #2 clock = ~clock;
	end

	// ---------------------------------------------------------------
	// Reference model and helpers
	// ---------------------------------------------------------------
	function automatic exp_type model();
		exp_type e;
		logic [7:0] a, oth, msk;
		logic [2:0] bn;
		logic m, b;
		e = '0;
		m = memTarget && (opCode >= OP_BIT_ONE_WRITE);
		a = m ? (woV ? 8'hFF : mByte) : destData;
		oth = useImm ? immData : srcData;
		bn = (bitFromReg && !(opCode inside {OP_CARRY_AND_INVERTED_BIT, OP_CARRY_OR_INVERTED_BIT,
			OP_CARRY_XOR_INVERTED_BIT, OP_INVERTED_BIT_TO_CARRY, OP_INVERTED_CARRY_TO_BIT})) ? srcData[2:0] : bitImm;
		b = a[bn];
		msk = 8'h01 << bn;
		e.mR = m;
		e.addr = memAddrIn;
		case (opCode)
			OP_AND: e.res = a & oth;
			OP_OR: e.res = a | oth;
			OP_XOR: e.res = a ^ oth;
			OP_NOT: e.res = ~a;
			OP_ARITH_LEFT_SHIFT, OP_LOGIC_LEFT_SHIFT: {e.c, e.res} = {a, 1'h0};
			OP_ARITH_RIGHT_SHIFT: {e.res, e.c} = {a[7], a};
			OP_LOGIC_RIGHT_SHIFT: {e.res, e.c} = {1'h0, a};
			OP_ROTATE_LEFT: {e.c, e.res} = {a[7], a[6:0], a[7]};
			OP_ROTATE_RIGHT: {e.res, e.c} = {a[0], a};
			OP_ROTATE_LEFT_VIA_CARRY: {e.c, e.res} = {a, carryIn};
			OP_ROTATE_RIGHT_VIA_CARRY: {e.res, e.c} = {carryIn, a};
			OP_BIT_ONE_WRITE: e.res = a | msk;
			OP_BIT_ZERO_WRITE: e.res = a & ~msk;
			OP_BIT_INVERT: e.res = a ^ msk;
			OP_CARRY_TO_BIT: e.res = carryIn ? (a | msk) : (a & ~msk);
			OP_INVERTED_CARRY_TO_BIT: e.res = carryIn ? (a & ~msk) : (a | msk);
			OP_BIT_PROBE: {e.zW, e.z} = {1'h1, ~b};
			OP_CARRY_AND_BIT: {e.cW, e.c} = {1'h1, carryIn & b};
			OP_CARRY_AND_INVERTED_BIT: {e.cW, e.c} = {1'h1, carryIn & ~b};
			OP_CARRY_OR_BIT: {e.cW, e.c} = {1'h1, carryIn | b};
			OP_CARRY_OR_INVERTED_BIT: {e.cW, e.c} = {1'h1, carryIn | ~b};
			OP_CARRY_XOR_BIT: {e.cW, e.c} = {1'h1, carryIn ^ b};
			OP_CARRY_XOR_INVERTED_BIT: {e.cW, e.c} = {1'h1, carryIn ^ ~b};
			OP_BIT_TO_CARRY: {e.cW, e.c} = {1'h1, b};
			default: {e.cW, e.c} = {1'h1, ~b};
		endcase
		if (opCode < OP_BIT_ONE_WRITE) begin
			{e.rW, e.nW, e.zW, e.n} = {3'h7, e.res[7]};
			e.z = (e.res == 8'h00);
			e.cW = (opCode >= OP_ARITH_LEFT_SHIFT);
		end else if (opCode inside {OP_BIT_ONE_WRITE, OP_BIT_ZERO_WRITE, OP_BIT_INVERT, OP_CARRY_TO_BIT,
			OP_INVERTED_CARRY_TO_BIT}) begin
			{e.rW, e.mW, e.mD} = {!m, m, e.res};
		end
		return e;
	endfunction

	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		nTests++;
		if (got !== exp) begin
			mismatches++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic rnd();
		{destData, srcData, immData, mByte} = 32'($urandom);
		{useImm, bitFromReg, carryIn, bitImm} = 6'($urandom);
		memAddrIn = 16'($urandom);
		woV = ($urandom_range(0, 3) == 0);
	endtask

	// A duplicate strobe is held one extra edge while busy and must be ignored.
	task automatic go(input logic dup);
		int k;
		q.push_back(model());
		startValid = 1'h1;
		@(posedge clock);
		#1;
		chk(16'(busy_ff), 16'h0001);
		if (dup) begin
			opCode = OP_NOT;
			destData = ~destData;
			@(posedge clock);
			#1;
		end
		startValid = 1'h0;
		k = 0;
		while (done_ff !== 1'h1 && k < 60) begin
			@(posedge clock);
			#1;
			k++;
		end
		if (k >= 60) begin
			mismatches++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, done_ff, 1'h1);
		end
	endtask

	task automatic conclude();
		$display("Comparisons %0d, mismatches %0d", nTests, mismatches);
		if (mismatches == 0 && nTests > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask

	// ---------------------------------------------------------------
	// Memory responder and result monitor
	// ---------------------------------------------------------------
	initial begin
		forever begin
			@(posedge clock);
			if (memRead_ff === 1'h1) begin
				rdSeen = 1'h1;
				repeat ($urandom_range(0, 3)) @(posedge clock);
				#1;
				{memRdValid, memRdData, memWriteOnly} = {1'h1, mByte, woV};
				@(posedge clock);
				#1;
				{memRdValid, memRdData, memWriteOnly} = {1'h0, ~mByte, ~woV};
			end
		end
	end

	always @(posedge clock) begin
		exp_type e;
		if (done_ff === 1'h1) begin
			if (q.size() == 0) begin
				mismatches++;
				$display("MISMATCH t=%0t got=%h exp=%h", $time, 32'(q.size()), 32'h0000_0001);
			end else begin
				e = q.pop_front();
				chk(16'(resultWrite_ff), 16'(e.rW));
				if (e.rW) chk(16'(result_ff), 16'(e.res));
				chk(16'(carryWrite_ff), 16'(e.cW));
				if (e.cW) chk(16'(carry_ff), 16'(e.c));
				chk(16'(zeroWrite_ff), 16'(e.zW));
				if (e.zW) chk(16'(zero_ff), 16'(e.z));
				chk(16'(negWrite_ff), 16'(e.nW));
				if (e.nW) chk(16'(negative_ff), 16'(e.n));
				chk(16'(rdSeen), 16'(e.mR));
				chk(16'(memWrite_ff), 16'(e.mW));
				if (e.mR) chk(memAddr_ff, e.addr);
				if (e.mW) chk(16'(memWrData_ff), 16'(e.mD));
			end
			rdSeen = 1'h0;
		end
	end

	// ---------------------------------------------------------------
	// Main sequence and watchdog
	// ---------------------------------------------------------------
	initial begin
		{rst, startValid, useImm, bitFromReg, memTarget, carryIn, memRdValid, memWriteOnly} = 8'hFF & 8'h80;
		{destData, srcData, immData, memRdData, mByte, bitImm, memAddrIn} = '0;
		{woV, rdSeen} = 2'h0;
		opCode = OP_AND;
		seedVal = $urandom(25168);
		repeat (16) @(posedge clock);
		#1;
		rst = 1'h0;
		for (int m = 0; m < 2; m++) begin
			for (int o = 0; o < 26; o++) begin
				repeat (20) begin
					opCode = op_type'(o);
					rnd();
					memTarget = m[0];
					go(1'h0);
				end
			end
		end
		opCode = OP_BIT_ZERO_WRITE;
		rnd();
		{memTarget, bitFromReg, bitImm, mByte, woV} = {2'h2, 3'h0, 8'h3F, 1'h1};
		go(1'h0);
		opCode = OP_AND;
		rnd();
		memTarget = 1'h0;
		go(1'h1);
		opCode = OP_BIT_INVERT;
		rnd();
		memTarget = 1'h1;
		go(1'h1);
		repeat (8) @(posedge clock);
		#1;
		rst = 1'h1;
		@(posedge clock);
		#1;
		chk(16'({busy_ff, done_ff, memWrite_ff, result_ff}), 16'h0000);
		repeat (2) @(posedge clock);
		#1;
		rst = 1'h0;
		opCode = OP_ROTATE_RIGHT_VIA_CARRY;
		rnd();
		go(1'h0);
		repeat (8) @(posedge clock);
		chk(16'(q.size()), 16'h0000);
		conclude();
	end

	initial begin
		#200000;
		mismatches++;
		conclude();
	end
endmodule
`default_nettype wire
